// *** hw/keyed_watchdog_interval_timer.v ***
// Purpose: eight bit watchdog / interval timer with keyed register writes
// Assumes: register port signals synchronous to clk; wr_t3 marks last write state
// Notes: byte reads only; word writes only
`timescale 1ns/1ps
`include "wdt_consts.vh"
module keyed_watchdog_interval_timer (
    input wire clk,
    input wire srst,
    input wire reset_pin_n,
    input wire [`ADDR_WIDTH-1:0] addr,
    input wire wr_en,
    input wire word_access,
    input wire wr_t3,
    input wire [15:0] wr_data,
    input wire rd_en,
    output reg [7:0] rd_data,
    input wire standby_req,
    input wire nmi,
    output wire standby_grant,
    output reg in_standby,
    output reg overflow_out_n,
    output reg interval_interrupt,
    output reg chip_reset,
    output reg chip_reset_manual
);
    reg [7:0] up_counter_q;
    reg interval_overflow_flag_q;
    reg watchdog_mode_select_q;
    reg timer_enable_q;
    reg [2:0] prescale_select_q;
    reg watchdog_overflow_flag_q;
    reg reset_enable_q;
    reg reset_select_q;
    reg ovf_seen_q;
    reg recovering_q;
    reg [7:0] ovf_cnt_q;
    reg [9:0] rst_cnt_q;
    wire pin_rst;
    wire tick;
    wire overflow;
    wire wr_shared;
    wire wr_rst;
    wire wr_cnt;
    wire wr_csr;
    wire counting;
    wire [7:0] csr_rd;
    wire [7:0] rst_rd;
    assign pin_rst = srst || !reset_pin_n;
    // ==========================================
    // write decode
    assign wr_shared = wr_en && word_access && (addr == `ADDR_CNT_CSR_WR);
    assign wr_rst = wr_en && word_access && (addr == `ADDR_RST_WR);
    assign wr_cnt = wr_shared && (wr_data[15:8] == `KEY_CNT);
    assign wr_csr = wr_shared && (wr_data[15:8] == `KEY_CSR);
    // ==========================================
    // count clock
    assign counting = timer_enable_q || recovering_q;
    wdt_prescaler wdt_prescaler_inst (
        .clk(clk),
        .srst(pin_rst),
        .run(counting),
        .sel(prescale_select_q),
        .tick(tick)
    );
    // tick in the write's T3 loses to the write
    assign overflow = tick && !(wr_cnt && wr_t3) && !wr_cnt && (up_counter_q == 8'hff);
    // ==========================================
    // counter
    always @(posedge clk) begin
        if (pin_rst) begin
            up_counter_q <= `CNT_RESET;
        end else if (wr_cnt) begin
            up_counter_q <= wr_data[7:0];
        end else if (!counting) begin
            up_counter_q <= `CNT_RESET;
        end else if (overflow && watchdog_mode_select_q && !recovering_q) begin
            up_counter_q <= `CNT_RESET;
        end else if (tick) begin
            up_counter_q <= up_counter_q + 8'h01;
        end
    end
    // ==========================================
    // control/status
    always @(posedge clk) begin
        if (pin_rst) begin
            interval_overflow_flag_q <= 1'b0;
            watchdog_mode_select_q <= 1'b0;
            timer_enable_q <= 1'b0;
            prescale_select_q <= 3'h0;
        end else if (overflow && watchdog_mode_select_q && !recovering_q) begin
            // internal reinitialise; prescale survives only in standby
            interval_overflow_flag_q <= 1'b0;
            watchdog_mode_select_q <= 1'b0;
            timer_enable_q <= 1'b0;
            prescale_select_q <= 3'h0;
        end else begin
            if (in_standby) begin
                interval_overflow_flag_q <= 1'b0;
                watchdog_mode_select_q <= 1'b0;
                timer_enable_q <= 1'b0;
            end else if (wr_csr) begin
                watchdog_mode_select_q <= wr_data[`CSR_MODE_BIT];
                timer_enable_q <= wr_data[`CSR_EN_BIT];
                prescale_select_q <= wr_data[2:0];
            end
            // set wins over clear
            if (overflow && !watchdog_mode_select_q && !recovering_q) begin
                interval_overflow_flag_q <= 1'b1;
            end else if (wr_csr && ovf_seen_q && !wr_data[`CSR_OVF_BIT]) begin
                interval_overflow_flag_q <= 1'b0;
            end
        end
    end
    // read-one tracking for the clear-by-zero sequence
    always @(posedge clk) begin
        if (pin_rst || wr_csr) begin
            ovf_seen_q <= 1'b0;
        end else if (rd_en && addr == `ADDR_CSR_RD && interval_overflow_flag_q) begin
            ovf_seen_q <= 1'b1;
        end
    end
    // ==========================================
    // reset control/status; pin reset wins and clears the flag
    always @(posedge clk) begin
        if (pin_rst) begin
            watchdog_overflow_flag_q <= 1'b0;
            reset_enable_q <= 1'b0;
            reset_select_q <= 1'b0;
        end else if (in_standby) begin
            watchdog_overflow_flag_q <= 1'b0;
            reset_enable_q <= 1'b0;
            reset_select_q <= 1'b0;
        end else begin
            if (overflow && watchdog_mode_select_q) begin
                watchdog_overflow_flag_q <= 1'b1;
            end else if (wr_rst && wr_data == {`KEY_RST_CLR, 8'h00}) begin
                watchdog_overflow_flag_q <= 1'b0;
            end
            if (wr_rst && wr_data[15:8] == `KEY_RST_SET) begin
                reset_enable_q <= wr_data[`RST_RESET_ENABLE_BIT];
                reset_select_q <= wr_data[`RST_RESET_SELECT_BIT];
            end
        end
    end
    // ==========================================
    // overflow pulse and internal reset
    always @(posedge clk) begin
        if (pin_rst) begin
            ovf_cnt_q <= 8'h00;
            rst_cnt_q <= 10'h000;
            overflow_out_n <= 1'b1;
            chip_reset <= 1'b0;
            chip_reset_manual <= 1'b0;
            interval_interrupt <= 1'b0;
        end else begin
            interval_interrupt <= overflow && !watchdog_mode_select_q && !recovering_q;
            if (overflow && watchdog_mode_select_q && !recovering_q) begin
                ovf_cnt_q <= `OVF_PULSE_CYCLES - 8'h01;
                overflow_out_n <= 1'b0;
            end else if (ovf_cnt_q != 8'h00) begin
                ovf_cnt_q <= ovf_cnt_q - 8'h01;
            end else begin
                overflow_out_n <= 1'b1;
            end
            if (overflow && watchdog_mode_select_q && reset_enable_q && !recovering_q) begin
                rst_cnt_q <= `RST_PULSE_CYCLES - 10'h001;
                chip_reset <= 1'b1;
                chip_reset_manual <= reset_select_q;
            end else if (rst_cnt_q != 10'h000) begin
                rst_cnt_q <= rst_cnt_q - 10'h001;
            end else begin
                chip_reset <= 1'b0;
            end
        end
    end
    // ==========================================
    // standby entry and nmi recovery
    assign standby_grant = standby_req && !timer_enable_q && !in_standby;
    always @(posedge clk) begin
        if (pin_rst) begin
            in_standby <= 1'b0;
            recovering_q <= 1'b0;
        end else if (standby_grant) begin
            in_standby <= 1'b1;
        end else if (in_standby && nmi && !recovering_q) begin
            recovering_q <= 1'b1;
        end else if (recovering_q && tick && up_counter_q == 8'hff) begin
            recovering_q <= 1'b0;
            in_standby <= 1'b0;
        end
    end
    // ==========================================
    // byte reads
    assign csr_rd = {interval_overflow_flag_q, watchdog_mode_select_q, timer_enable_q,
                     `CSR_RESERVED, prescale_select_q};
    assign rst_rd = {watchdog_overflow_flag_q, reset_enable_q, reset_select_q, `RST_RESERVED};
    always @(posedge clk) begin
        if (pin_rst) begin
            rd_data <= 8'h00;
        end else if (rd_en) begin
            case (addr)
                `ADDR_CSR_RD: rd_data <= csr_rd;
                `ADDR_CNT_RD: rd_data <= up_counter_q;
                `ADDR_RST_RD: rd_data <= rst_rd;
                default: rd_data <= 8'h00;
            endcase
        end
    end
endmodule // keyed_watchdog_interval_timer

// *** hw/wdt_consts.vh ***
// Purpose: constants for the keyed watchdog / interval timer
// Assumes: byte addresses as seen on the internal register port
// Notes: definitions only
`ifndef WDT_CONSTS_VH
`define WDT_CONSTS_VH
// ==========================================
// addresses
`define ADDR_WIDTH 32
`define ADDR_CSR_RD 32'h05ffffb8
`define ADDR_CNT_RD 32'h05ffffb9
`define ADDR_CNT_CSR_WR 32'h05ffffb8
`define ADDR_RST_RD 32'h05ffffbb
`define ADDR_RST_WR 32'h5fffffba
// ==========================================
// write keys
`define KEY_CNT 8'h5a
`define KEY_CSR 8'ha5
`define KEY_RST_CLR 8'ha5
`define KEY_RST_SET 8'h5a
// ==========================================
// field positions
`define CSR_OVF_BIT 7
`define CSR_MODE_BIT 6
`define CSR_EN_BIT 5
`define RST_WATCHDOG_OVERFLOW_FLAG_BIT 7
`define RST_RESET_ENABLE_BIT 6
`define RST_RESET_SELECT_BIT 5
// ==========================================
// reset values and reserved bits
`define CSR_RESERVED 2'h3
`define RST_RESERVED 5'h1f
`define CNT_RESET 8'h00
// ==========================================
// timing
`define CLK_PERIOD_NS 10
`define OVF_PULSE_CYCLES 8'd128
`define RST_PULSE_CYCLES 10'd512
`define PRESCALE_WIDTH 13
`endif

// *** hw/wdt_prescaler.v ***
// Purpose: divider, cleared while run is low, giving one-cycle count enables
// Assumes: single clock, synchronous reset
// Notes: tap chosen by a three bit select
`timescale 1ns/1ps
`include "wdt_consts.vh"
module wdt_prescaler (
    input wire clk,
    input wire srst,
    input wire run,
    input wire [2:0] sel,
    output reg tick
);
    reg [`PRESCALE_WIDTH-1:0] div_q;
    reg [`PRESCALE_WIDTH-1:0] mask;
    // ==========================================
    // divider
    always @(posedge clk) begin
        if (srst || !run) begin
            div_q <= {`PRESCALE_WIDTH{1'b0}};
        end else begin
            div_q <= div_q + 13'h0001;
        end
    end
    // ==========================================
    // tap select: /2,/64,/128,/256,/512,/1024,/4096,/8192
    always @* begin
        case (sel)
            3'h0: mask = 13'h0001;
            3'h1: mask = 13'h003f;
            3'h2: mask = 13'h007f;
            3'h3: mask = 13'h00ff;
            3'h4: mask = 13'h01ff;
            3'h5: mask = 13'h03ff;
            3'h6: mask = 13'h0fff;
            default: mask = 13'h1fff;
        endcase
        tick = run && ((div_q & mask) == mask);
    end
endmodule // wdt_prescaler

// *** tb/wdt_asserts.sv ***
// Purpose: port checker for keyed_watchdog_interval_timer
// Assumes: one clock, synchronous resets
// Notes: pulse lengths counted in helper logic, since a repetition of 512 is too costly
`timescale 1ns/1ps
// ==========================================
// checker
module wdt_asserts (
    input wire clk,
    input wire srst,
    input wire reset_pin_n,
    input wire rd_en,
    input wire [7:0] rd_data,
    input wire standby_req,
    input wire standby_grant,
    input wire in_standby,
    input wire overflow_out_n,
    input wire interval_interrupt,
    input wire chip_reset,
    input wire chip_reset_manual
);
wire rst_any = srst | ~reset_pin_n;
reg [7:0] lo_q;
reg [9:0] hi_q;
always @(posedge clk) begin
    lo_q <= (rst_any | overflow_out_n) ? 8'h00 : lo_q + 8'h01;
    hi_q <= (rst_any | ~chip_reset) ? 10'h000 : hi_q + 10'h001;
end
default clocking @(posedge clk); endclocking
default disable iff (rst_any);
sequence wd_start; $fell(overflow_out_n); endsequence
// a reset cut short the pulse, so its length proves nothing
sequence wd_end; $rose(overflow_out_n) && !$past(rst_any); endsequence
a_ovf_short: assert property (!overflow_out_n |-> lo_q < 8'h80) else $error("pulse long");
a_ovf_len: assert property (wd_end |-> lo_q == 8'h80) else $error("pulse length");
a_rst_short: assert property (chip_reset |-> hi_q < 10'h200) else $error("reset long");
a_rst_len: assert property ($fell(chip_reset) && !$past(rst_any) |-> hi_q == 10'h200)
    else $error("reset length");
a_rst_sync: assert property ($rose(chip_reset) |-> wd_start) else $error("reset without pulse");
a_type_hold: assert property (chip_reset && $past(chip_reset) |-> $stable(chip_reset_manual))
    else $error("reset type moved");
a_irq_pulse: assert property (interval_interrupt |=> !interval_interrupt) else $error("irq long");
a_irq_mode: assert property (interval_interrupt |-> overflow_out_n && !chip_reset)
    else $error("irq in watchdog");
a_reset_vals: assert property ($past(rst_any) |-> overflow_out_n && !chip_reset && !in_standby
    && !interval_interrupt && rd_data == 8'h00) else $error("reset values");
a_rd_hold: assert property (!rd_en |=> $stable(rd_data)) else $error("read data moved");
a_grant_idle: assert property (standby_grant |-> (standby_req && !in_standby) ##1 in_standby)
    else $error("bad grant");
endmodule // wdt_asserts
bind keyed_watchdog_interval_timer wdt_asserts wdt_asserts_inst (.clk(clk), .srst(srst),
    .reset_pin_n(reset_pin_n), .rd_en(rd_en), .rd_data(rd_data), .standby_req(standby_req),
    .standby_grant(standby_grant), .in_standby(in_standby), .overflow_out_n(overflow_out_n),
    .interval_interrupt(interval_interrupt), .chip_reset(chip_reset), .chip_reset_manual(chip_reset_manual));

// *** tb/keyed_watchdog_interval_timer_test.sv ***
// Purpose: self-checking bench for keyed_watchdog_interval_timer
// Assumes: 100 MHz clk, srst held 20 cycles
// Notes: reads checked from a queue; counter preloads keep overflows short
`timescale 1ns/1ps
`include "wdt_consts.vh"
// ==========================================
// bench
module keyed_watchdog_interval_timer_test;
localparam [31:0] csr_a = `ADDR_CSR_RD;
localparam [31:0] cnt_a = `ADDR_CNT_RD;
localparam [31:0] rst_a = `ADDR_RST_RD;
localparam [31:0] key_a = `ADDR_CNT_CSR_WR;
localparam [31:0] rsw_a = `ADDR_RST_WR;
reg clk = 1'b0, srst = 1'b1, reset_pin_n = 1'b1, wr_en = 1'b0, word_access = 1'b0, wr_t3 = 1'b0;
reg rd_en = 1'b0, standby_req = 1'b0, nmi = 1'b0, rd_q = 1'b0;
reg [31:0] addr = 32'h00000000, seed = 32'h00016e83;
reg [15:0] wr_data = 16'h0000;
reg [7:0] expq[$];
wire [7:0] rd_data;
wire standby_grant, in_standby, overflow_out_n, interval_interrupt, chip_reset, chip_reset_manual;
integer error_cnt = 0, samples_checked = 0, n, i;
keyed_watchdog_interval_timer keyed_watchdog_interval_timer_inst (.clk(clk), .srst(srst),
    .reset_pin_n(reset_pin_n), .addr(addr), .wr_en(wr_en), .word_access(word_access), .wr_t3(wr_t3),
    .wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data), .standby_req(standby_req), .nmi(nmi),
    .standby_grant(standby_grant), .in_standby(in_standby), .overflow_out_n(overflow_out_n),
    .interval_interrupt(interval_interrupt), .chip_reset(chip_reset), .chip_reset_manual(chip_reset_manual));
initial forever #5 clk = ~clk;
function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
endfunction
function cur(input integer s);
    case (s)
        0: cur = interval_interrupt;
        1: cur = overflow_out_n;
        2: cur = chip_reset;
        default: cur = in_standby;
    endcase
endfunction
task check(input [63:0] nm, input [9:0] seen, input [9:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] %0s exp %h seen %h", nm, exp, seen);
    end
endtask
task wr(input [31:0] a, input [15:0] d, input w = 1'b1);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    word_access <= w;
    wr_en <= 1'b1;
    wr_t3 <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    wr_t3 <= 1'b0;
endtask
task rd(input [31:0] a, input [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    expq.push_back(e);
    @(posedge clk);
    rd_en <= 1'b0;
endtask
task wait_sig(input integer s, input v, input integer lim);
    n = 0;
    while (cur(s) !== v && n < lim) begin
        @(posedge clk);
        n = n + 1;
    end
endtask
task give_verdict;
    if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
endtask
always @(posedge clk) begin
    if (rd_q) check("rd_data", rd_data, {2'b00, expq.pop_front()});
    rd_q <= rd_en;
end
initial begin
    // tests take about 3700 cycles; allow over five times that
    #200000;
    error_cnt = error_cnt + 1;
    give_verdict;
end
initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rd(csr_a, 8'h18);
    rd(cnt_a, 8'h00);
    rd(rst_a, 8'h1f);
    rd(32'h05ffffba, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
        seed = xs(seed);
        wr(key_a, seed[15:0], 1'b0);
        wr(rsw_a, seed[31:16], 1'b0);
    end
    wr(key_a, 16'h3327);
    rd(csr_a, 8'h18);
    rd(rst_a, 8'h1f);
    seed = xs(seed);
    wr(rsw_a, {8'h5a, seed[7:0]});
    rd(rst_a, {1'b0, seed[6:5], 5'h1f});
    // interval mode, counter preloaded so the /2 tap overflows at once
    wr(key_a, 16'ha520);
    wr(key_a, 16'h5afe);
    wait_sig(0, 1'b1, 50);
    check("irq", interval_interrupt, 1);
    rd(csr_a, 8'hb8);
    wr(key_a, 16'ha520);
    rd(csr_a, 8'h38);
    wait_sig(0, 1'b1, 600);
    check("irq2", interval_interrupt, 1);
    wr(key_a, 16'ha500);
    rd(cnt_a, 8'h00);
    // counter write lands on a /2 tick; the written value must survive
    wr(key_a, 16'ha520);
    wr(key_a, 16'h5a10);
    rd(cnt_a, 8'h10);
    wr(key_a, 16'ha500);
    wr(key_a, 16'ha521);
    wr(key_a, 16'h5a00);
    repeat (200) @(posedge clk);
    rd(cnt_a, 8'h03);
    wr(key_a, 16'ha500);
    // watchdog mode without chip reset
    wr(rsw_a, 16'h5a00);
    wr(key_a, 16'ha560);
    wr(key_a, 16'h5afe);
    wait_sig(1, 1'b0, 50);
    n = 0;
    while (overflow_out_n === 1'b0 && n < 300) begin
        @(posedge clk);
        n = n + 1;
    end
    check("ovf_len", n, 128);
    check("creset", chip_reset, 0);
    rd(rst_a, 8'h9f);
    rd(csr_a, 8'h18);
    rd(cnt_a, 8'h00);
    wr(rsw_a, 16'h5a60);
    rd(rst_a, 8'hff);
    wr(rsw_a, 16'ha500);
    rd(rst_a, 8'h7f);
    // regular kicks keep the watchdog from ever overflowing
    wr(key_a, 16'ha560);
    for (i = 0; i < 3; i = i + 1) begin
        repeat (400) @(posedge clk);
        check("kick", overflow_out_n, 1);
        wr(key_a, 16'h5a00);
    end
    wr(key_a, 16'ha500);
    rd(rst_a, 8'h7f);
    // chip reset, power-on type then manual type
    for (i = 0; i < 2; i = i + 1) begin
        wr(rsw_a, {10'h169, i[0], 5'h00});
        wr(key_a, 16'ha560);
        wr(key_a, 16'h5afe);
        wait_sig(2, 1'b1, 50);
        check("creset", chip_reset, 1);
        check("ovf_n", overflow_out_n, 0);
        check("rtype", chip_reset_manual, i[0]);
        wr(key_a, 16'ha500);
        wait_sig(2, 1'b0, 600);
        check("rst_end", chip_reset, 0);
    end
    reset_pin_n <= 1'b0;
    @(posedge clk);
    reset_pin_n <= 1'b1;
    rd(rst_a, 8'h1f);
    wr(key_a, 16'ha520);
    standby_req <= 1'b1;
    repeat (3) @(posedge clk);
    check("grant", standby_grant, 0);
    wr(key_a, 16'ha500);
    wait_sig(3, 1'b1, 20);
    check("stby", in_standby, 1);
    standby_req <= 1'b0;
    nmi <= 1'b1;
    @(posedge clk);
    nmi <= 1'b0;
    wait_sig(3, 1'b0, 1000);
    check("wake", in_standby, 0);
    repeat (3) @(posedge clk);
    give_verdict;
end
endmodule // keyed_watchdog_interval_timer_test
